// ===== common/wdt_pkg.sv
package wdt_pkg;
  // --------------------------------------------------------------------------
  // Register map (peripheral control frame)
  // --------------------------------------------------------------------------
  localparam logic [15:0] WDT_FRAME_BASE = 16'h7020;
  localparam logic [15:0] WDT_OFF_COUNT = 16'h0003;
  localparam logic [15:0] WDT_OFF_KEY = 16'h0005;
  localparam logic [15:0] WDT_OFF_CTRL = 16'h0009;
  localparam logic [15:0] WDT_ADDR_COUNT = WDT_FRAME_BASE + WDT_OFF_COUNT;
  localparam logic [15:0] WDT_ADDR_KEY = WDT_FRAME_BASE + WDT_OFF_KEY;
  localparam logic [15:0] WDT_ADDR_CTRL = WDT_FRAME_BASE + WDT_OFF_CTRL;

  // --------------------------------------------------------------------------
  // Field layout of the timeout control register
  // --------------------------------------------------------------------------
  localparam int WDT_CHK_LSB = 3;
  localparam int WDT_CHK_MSB = 5;
  localparam logic [2:0] WDT_CHK_PATTERN = 3'h5;
  localparam int WDT_PS_LSB = 0;
  localparam int WDT_PS_MSB = 2;
  localparam int WDT_FLAG_BIT = 7;
  localparam logic [2:0] WDT_PS_RESET = 3'h0;
  // Arbitrary service key value
  localparam logic [7:0] WDT_KEY_DEFAULT = 8'hA5;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int WDT_CLK_MHZ = 125;
  localparam int WDT_SRC_MHZ = 5;
  localparam int WDT_TICK_HZ_X10 = 390625;
  // 5 MHz / 128 gives the 39.0625 kHz slow tick
  localparam int WDT_TICK_DIV = (WDT_SRC_MHZ * 1000000 * 10) / WDT_TICK_HZ_X10;
  localparam int WDT_SRC_DIV = WDT_CLK_MHZ / WDT_SRC_MHZ;
  localparam int WDT_TICK_CYCLES = WDT_SRC_DIV * WDT_TICK_DIV;
  localparam int WDT_RST_PULSE = 16;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } wdt_bus_req_t;
endpackage

// ===== src/wdt_core.sv
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
// Functional notes
// - Counter timeout without valid service asserts system reset.
// - Runs on its own, always enabled, needs no software setup.
// - Any system reset returns prescale select to fastest timeout.
// - Counter starts incrementing as soon as internal reset releases.
// - Prescale select 00x..111 divides slow tick by 1 to 64.
// - Correct key clears counter; wrong key resets system at once.
// - Control writes need check bits 101; other patterns reset system.
// - Registers eight bits in low byte; upper byte reads zero.
// - Three registers in the frame based at 7020h.
// - Slow tick of 39.0625 kHz derived from 5 MHz source.
module wdt_core
  import wdt_pkg::*;
#(
  parameter logic [7:0] SERVICE_KEY = WDT_KEY_DEFAULT,
  parameter int TICK_CYCLES = WDT_TICK_CYCLES
)(
  input wire logic clk, // System clock, 125 MHz
  input wire logic sys_rst, // Async reset, active high
  input wire logic [15:0] bus_addr, // Register address
  input wire logic [15:0] bus_wdata, // Write data
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  output logic [15:0] bus_rdata, // Read data, cycle after strobe
  output logic wd_reset // System reset request
);
  import wdt_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [6:0] pre;
    logic [7:0] count;
    logic [2:0] ps;
    logic flag;
    logic [4:0] rst_cnt;
    logic rst;
    logic [15:0] rdata;
  } wdt_state_t;

  wdt_state_t s_q;
  wdt_state_t s_d;
  wdt_bus_req_t req;
  logic tick;
  logic ps_hit;
  logic key_hit;
  logic key_bad;
  logic ctrl_hit;
  logic ctrl_bad;
  logic timeout;

  localparam logic [4:0] RST_LAST = 5'(WDT_RST_PULSE);

  function automatic logic [6:0] ps_mask(input logic [2:0] sel);
    logic [6:0] m;
    m = 7'h00;
    unique case (sel)
      3'h0, 3'h1: m = 7'h00;
      3'h2: m = 7'h01;
      3'h3: m = 7'h03;
      3'h4: m = 7'h07;
      3'h5: m = 7'h0F;
      3'h6: m = 7'h1F;
      3'h7: m = 7'h3F;
    endcase
    return m;
  endfunction

  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  // --------------------------------------------------------------------------
  // Slow tick
  // --------------------------------------------------------------------------
  wdt_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  always_comb
  begin
    key_hit = req.wr && (req.addr == WDT_ADDR_KEY);
    ctrl_hit = req.wr && (req.addr == WDT_ADDR_CTRL);
    key_bad = key_hit && (req.wdata[7:0] != SERVICE_KEY);
    ctrl_bad = ctrl_hit
      && (req.wdata[WDT_CHK_MSB:WDT_CHK_LSB] != WDT_CHK_PATTERN);
    ps_hit = tick && ((s_q.pre & ps_mask(s_q.ps)) == ps_mask(s_q.ps));
    timeout = ps_hit && (s_q.count == 8'hFF);
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Prescaler and counter run free from reset release, no enable bit exists
    if (tick)
      s_d.pre = s_q.pre + 7'h01;
    if (ps_hit)
      s_d.count = s_q.count + 8'h01;
    if (key_hit && !key_bad)
      s_d.count = 8'h00;
    if (ctrl_hit && !ctrl_bad)
    begin
      s_d.ps = req.wdata[WDT_PS_MSB:WDT_PS_LSB];
      s_d.flag = s_q.flag & ~req.wdata[WDT_FLAG_BIT];
    end
    // Reset pulse; holding it stretched lets the system reset catch it
    if (timeout || key_bad || ctrl_bad)
    begin
      s_d.rst = 1'b1;
      s_d.rst_cnt = 5'h00;
      s_d.flag = 1'b1;
    end
    else if (s_q.rst)
    begin
      s_d.rst_cnt = s_q.rst_cnt + 5'h01;
      if (s_q.rst_cnt == RST_LAST - 5'h01)
        s_d.rst = 1'b0;
    end
    // The issued reset restarts timing at the fastest rate
    if (s_q.rst)
    begin
      s_d.ps = WDT_PS_RESET;
      s_d.count = 8'h00;
      s_d.pre = 7'h00;
    end
    s_d.rdata = 16'h0000;
    if (req.rd)
    begin
      unique case (req.addr)
        WDT_ADDR_COUNT: s_d.rdata = {8'h00, s_q.count};
        WDT_ADDR_KEY: s_d.rdata = 16'h0000;
        WDT_ADDR_CTRL: s_d.rdata = {8'h00, s_q.flag, 1'b0,
                                    WDT_CHK_PATTERN, s_q.ps};
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.ps <= WDT_PS_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign bus_rdata = s_q.rdata;
  assign wd_reset = s_q.rst;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_bad_key_reset: assert property (@(posedge clk) disable iff (sys_rst)
    key_bad |=> wd_reset)
    else $error("wrong key did not reset");
  a_bad_check_reset: assert property (@(posedge clk) disable iff (sys_rst)
    ctrl_bad |=> wd_reset)
    else $error("wrong check bits did not reset");
  a_timeout_reset: assert property (@(posedge clk) disable iff (sys_rst)
    timeout |=> wd_reset && s_q.flag)
    else $error("timeout did not reset");
  a_key_clears: assert property (@(posedge clk) disable iff (sys_rst)
    (key_hit && !key_bad && !s_q.rst) |=> (s_q.count == 8'h00))
    else $error("good key did not clear counter");
  a_ps_fast: assert property (@(posedge clk) disable iff (sys_rst)
    s_q.rst ##1 s_q.rst |-> s_q.ps == WDT_PS_RESET)
    else $error("prescale not fastest under reset");
  a_upper_zero: assert property (@(posedge clk) disable iff (sys_rst)
    bus_rdata[15:8] == 8'h00)
    else $error("upper byte not zero");
  a_count_step: assert property (@(posedge clk) disable iff (sys_rst)
    (ps_hit && !key_hit && !s_q.rst) |=> s_q.count == $past(s_q.count) + 8'h01)
    else $error("counter did not advance");
  a_read_ctrl: assert property (@(posedge clk) disable iff (sys_rst)
    (bus_rd && bus_addr == WDT_ADDR_CTRL) |=> bus_rdata[5:3] == WDT_CHK_PATTERN)
    else $error("control read wrong");
  a_no_stuck_rst: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(wd_reset) |-> ##[1:40] !wd_reset || timeout || key_bad || ctrl_bad)
    else $error("reset pulse stuck");
  a_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    (timeout || key_bad || ctrl_bad) |=> s_q.flag)
    else $error("reset flag not set");
  a_pulse_min: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(wd_reset) |-> wd_reset [*8])
    else $error("reset pulse too short");
  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !bus_rd |=> bus_rdata == 16'h0000)
    else $error("read data outside read cycle");

  c_timeout: cover property (@(posedge clk) disable iff (sys_rst) timeout);
  c_good_key: cover property (@(posedge clk) disable iff (sys_rst) key_hit && !key_bad);
  c_bad_key: cover property (@(posedge clk) disable iff (sys_rst) key_bad);
  c_bad_ctrl: cover property (@(posedge clk) disable iff (sys_rst) ctrl_bad);
endmodule

// ===== src/wdt_tick_gen.sv
`timescale 1ns/1ns
module wdt_tick_gen
  import wdt_pkg::*;
#(
  parameter int TICK_CYCLES = WDT_TICK_CYCLES
)(
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  output logic tick // One-cycle slow tick pulse
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } wdt_tick_state_t;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  wdt_tick_state_t s_q;
  wdt_tick_state_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == TICK_LAST)
    begin
      s_d.cnt = 16'h0000;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;

  a_tick_single: assert property (@(posedge clk) disable iff (sys_rst)
    tick |=> !tick)
    else $error("slow tick longer than one cycle");
endmodule

// ===== tb/test_watchdog_reset_timer.sv
`timescale 1ns/1ns
module test_watchdog_reset_timer;
  import wdt_pkg::*;
  // Short slow tick keeps the longest timeout within the run budget
  localparam int TCK = 2;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] bus_rdata;
  logic wd_reset;
  logic [15:0] rv;
  logic [15:0] rv0;
  int num_errors = 0;
  int cmp_count = 0;

  wdt_core #(.SERVICE_KEY(WDT_KEY_DEFAULT), .TICK_CYCLES(TCK)) dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .wd_reset(wd_reset)
  );

  initial
  begin
    forever #4 clk = ~clk;
  end

  // --------------------------------------------------------------------------
  // Bus and compare tasks
  // --------------------------------------------------------------------------
  // Strobe drops after its edge and one idle edge follows, so no signal is set twice at once
  task automatic bus_write(input logic [15:0] a, input logic [15:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bus_read(input logic [15:0] a, output logic [15:0] d);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
    @(posedge clk);
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_range(input int n, input int lo, input int hi);
    cmp_count++;
    if (n < lo || n > hi)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %0d outside %0d..%0d", $time, n, lo, hi);
    end
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 64 && wd_reset !== 1'b0; i++) @(posedge clk);
    check16({15'h0000, wd_reset}, 16'h0000);
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset_values();
    bus_read(WDT_ADDR_CTRL, rv);
    check16(rv, 16'h0028);
    bus_read(WDT_ADDR_KEY, rv);
    check16(rv, 16'h0000);
    bus_read(WDT_FRAME_BASE + 16'h0001, rv);
    check16(rv, 16'h0000);
  endtask

  task automatic t_counting();
    bus_read(WDT_ADDR_COUNT, rv0);
    repeat (40) @(posedge clk);
    bus_read(WDT_ADDR_COUNT, rv);
    check_range(int'(rv) - int'(rv0), 19, 23);
    bus_write(WDT_ADDR_KEY, {8'h00, WDT_KEY_DEFAULT});
    bus_read(WDT_ADDR_COUNT, rv);
    check_range(int'(rv), 0, 2);
  endtask

  task automatic t_upper_byte();
    bus_write(WDT_ADDR_CTRL, 16'h5A2F);
    bus_read(WDT_ADDR_CTRL, rv);
    check16(rv, 16'h002F);
    check16({15'h0000, wd_reset}, 16'h0000);
  endtask

  task automatic t_bad_key();
    bus_write(WDT_ADDR_KEY, 16'h00A4);
    #1 check16({15'h0000, wd_reset}, 16'h0001);
    wait_idle();
    bus_read(WDT_ADDR_CTRL, rv);
    check16(rv, 16'h00A8);
  endtask

  task automatic t_bad_check();
    for (int p = 0; p < 8; p++)
    begin
      if (p == 5) continue;
      wait_idle();
      bus_write(WDT_ADDR_CTRL, 16'(p << 3));
      #1 check16({15'h0000, wd_reset}, 16'h0001);
    end
    wait_idle();
    bus_write(WDT_ADDR_CTRL, 16'h00A8);
    bus_read(WDT_ADDR_CTRL, rv);
    check16(rv, 16'h0028);
  endtask

  // Prescaler phase survives a service, so allow one divided tick of slack
  task automatic t_timeouts();
    int n;
    int dv;
    for (int ps = 0; ps < 8; ps++)
    begin
      dv = (ps < 2) ? 1 : (1 << (ps - 1));
      wait_idle();
      bus_write(WDT_ADDR_CTRL, 16'h00A8 | 16'(ps));
      bus_write(WDT_ADDR_KEY, {8'h00, WDT_KEY_DEFAULT});
      n = 0;
      while (wd_reset !== 1'b1 && n < 70000)
      begin
        @(posedge clk);
        n++;
      end
      check_range(n, 255 * dv * TCK - 8, 256 * dv * TCK + 8);
    end
  endtask

  // --------------------------------------------------------------------------
  // Sequence, watchdog and verdict
  // --------------------------------------------------------------------------
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_counting();
    t_upper_byte();
    t_bad_key();
    t_bad_check();
    t_timeouts();
    end_of_test();
  end

  // Whole run needs about 66000 cycles; stop at 90000
  initial
  begin
    #720000;
    num_errors++;
    end_of_test();
  end
endmodule
